/* core/mas_pkg.sv */
// Shared constants for the motor alarm and status monitor.
// Assumes a 32-bit AHB-Lite slave port and one 100 MHz clock.
package mas_pkg;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned HIST_DEPTH = 10;
  localparam int unsigned HIST_AW    = 4;
  localparam int unsigned CODE_W     = 8;
  localparam int unsigned OPNUM_W    = 8;
  localparam int unsigned OPTYPE_W   = 4;
  localparam int unsigned STAT_W     = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INFO_EN   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_INFO_REFL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INFO_BITS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OP_NUM    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_OP_TYPE   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_HIST_SEL  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_HIST_DATA = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_HIST_CNT  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_ALM_STATE = 8'h2C;

  // Field positions and reset values
  localparam int unsigned CTRL_MECH_BIT    = 0;
  localparam int unsigned CTRL_AUTOCLR_BIT = 1;
  localparam logic [1:0]  CTRL_RST         = 2'h2;
  localparam int unsigned STAT_ALARM       = 0;
  localparam int unsigned STAT_RELEASE     = 1;
  localparam int unsigned STAT_INFO        = 2;
  localparam logic [STAT_W-1:0] MASK_RST   = 3'h0;
  localparam logic        INFO_EN_RST_BIT  = 1'b1;
  localparam logic        INFO_RF_RST_BIT  = 1'b1;

  localparam logic [OPNUM_W:0]    OP_NUM_NONE  = 9'h1FF;
  localparam logic [OPTYPE_W-1:0] OP_TYPE_IDLE = 4'h0;
  localparam logic [OPTYPE_W-1:0] OP_TYPE_RSVD = 4'hC;
  localparam logic [OPTYPE_W-1:0] OP_TYPE_MAX  = 4'hD;

  typedef enum {ST_RUN, ST_ALARM} mas_state_t;
endpackage : mas_pkg

/* core/mas_hist_if.sv */
// Write and read lanes between the monitor and its alarm history store.
// Assumes both ends share the monitor clock.
`timescale 1ns/1ps
interface mas_hist_if #(
  parameter int unsigned AW = 4,
  parameter int unsigned DW = 8
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : mas_hist_if

/* core/mas_hist_mem.sv */
// Alarm history store, one code per slot, registered read port.
// Assumes the controller keeps both addresses below DEPTH.
`timescale 1ns/1ps
module mas_hist_mem #(
  parameter int unsigned DEPTH = 10,
  parameter int unsigned DW    = 8
) (
  input  wire logic clock_i,
  input  wire logic ce_i,
  mas_hist_if.mem   hif
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      if (hif.wr_en) begin
        mem_q[hif.wr_addr] <= hif.wr_data;
      end
      hif.rd_data <= mem_q[hif.rd_addr];
    end
  end
endmodule : mas_hist_mem

/* core/mas_info.sv */
// Warning-level information flags with auto clear and reflect control.
// Assumes conditions arrive as synchronous levels from threshold logic.
`timescale 1ns/1ps
module mas_info #(
  parameter int unsigned N = 8
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [N-1:0] cond_i,
  input  wire logic [N-1:0] en_i,
  input  wire logic [N-1:0] reflect_i,
  input  wire logic         auto_clr_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] bits_o,
  output logic              info_o,
  output logic              raise_o
);
  logic [N-1:0] bits_d;
  logic [N-1:0] hit;

  assign hit = cond_i & en_i;

  for (genvar i = 0; i < N; i++) begin : g_flag
    always_comb begin
      bits_d[i] = bits_o[i];
      if (hit[i]) begin
        bits_d[i] = 1'b1;
      end else if (clr_i[i] || (auto_clr_i && !cond_i[i])) begin
        bits_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bits_o  <= '0;
      raise_o <= 1'b0;
    end else if (ce_i) begin
      bits_o  <= bits_d;
      raise_o <= |(bits_d & ~bits_o);
    end
  end

  // general output only for reflected flags
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      info_o <= 1'b0;
    end else if (ce_i) begin
      info_o <= |(bits_d & reflect_i);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_info_set: assert property (ce_i && hit != '0 |=>
    (bits_o & $past(hit)) == $past(hit))
    else $error("enabled condition did not raise its flag");
  a_info_refl: assert property (ce_i && (hit & reflect_i) != '0 |=>
    info_o)
    else $error("reflected flag did not raise general output");
  a_info_quiet: assert property (ce_i && (bits_d & reflect_i) == '0 |=>
    !info_o)
    else $error("general output high with no reflected flag");
endmodule : mas_info

/* core/mas_alarm_monitor.sv */
// Alarm latch, operation status and alarm history for a stepping driver.
// Assumes synchronous inputs, an AHB-Lite master and a single clock.
// Functional notes
// - On a fault, drop alarm-ok, motion-active and pulse-ready together.
// - Same edge, halt the motor at once with no ramp.
// - Clear input releases alarm; raise alarm-ok, ready and pulse-ready.
// - Data number reads -1 at power-up or without stored data.
// - Data number holds the last executed number while stopped.
// - Operation type is 0 to 13, value 12 never shown.
// - One config bit follows sensor limits (0) or disables them (1).
// - Keep last ten alarms, readable newest first.
// - Raise information flags from enabled conditions.
// - Information raises general output unless set to own bit only.
// - Information never stops the motor.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module mas_alarm_monitor
  import mas_pkg::*;
#(
  parameter int unsigned NFAULT = 8,
  parameter int unsigned NINFO  = 8
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [NFAULT-1:0]    fault_i,
  input  wire logic                 alarm_clear_in_i,
  input  wire logic                 op_start_i,
  input  wire logic                 op_busy_i,
  input  wire logic                 op_data_valid_i,
  input  wire logic [OPNUM_W-1:0]   op_data_num_i,
  input  wire logic [OPTYPE_W-1:0]  op_type_i,
  input  wire logic [NINFO-1:0]     info_cond_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  output logic                      alarm_ok_out_o,
  output logic                      pulse_input_ready_out_o,
  output logic                      motion_active_o,
  output logic                      ready_o,
  output logic                      motor_halt_o,
  output logic                      mech_prot_disable_o,
  output logic      [OPNUM_W:0]     op_info0_o,
  output logic      [OPTYPE_W-1:0]  op_info1_o,
  output logic      [NINFO-1:0]     info_bits_o,
  output logic                      info_out_o,
  output logic                      irq_o
);
  mas_state_t          state_q;
  logic                armed_q;
  logic [1:0]          ctrl_q;
  logic [STAT_W-1:0]   stat_q;
  logic [STAT_W-1:0]   mask_q;
  logic [NINFO-1:0]    info_en_q;
  logic [NINFO-1:0]    info_refl_q;
  logic [HIST_AW-1:0]  wp_q;
  logic [HIST_AW-1:0]  cnt_q;
  logic [HIST_AW-1:0]  sel_q;
  logic                wr_pend_q;
  logic [ADDR_W-1:0]   wa_q;
  logic                fault_any;
  logic                alarm_set;
  logic                alarm_rel;
  logic                acc;
  logic                rd_acc;
  logic                wr_now;
  logic [NINFO-1:0]    info_clr;
  logic                info_raise;
  logic [STAT_W-1:0]   stat_ev;
  logic [31:0]         rdata_d;
  logic [4:0]          ri;

  mas_hist_if #(.AW(HIST_AW), .DW(CODE_W)) hist_if ();

  // Lowest set fault bit plus one; zero means no fault
  function automatic logic [CODE_W-1:0] fault_code(
    input logic [NFAULT-1:0] f
  );
    fault_code = 8'h00;
    for (int i = NFAULT - 1; i >= 0; i--) begin
      if (f[i]) begin
        fault_code = CODE_W'(i + 1);
      end
    end
  endfunction : fault_code

  function automatic logic [31:0] zext(input logic [NINFO-1:0] v);
    zext = 32'(v);
  endfunction : zext

  assign fault_any = |fault_i;
  assign alarm_set = ce_i && (state_q == ST_RUN) && fault_any;
  // release needs clear with every cause gone
  assign alarm_rel = ce_i && (state_q == ST_ALARM) && alarm_clear_in_i
                     && !fault_any;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else if (ce_i) begin
      case (state_q)
        ST_RUN: begin
          if (fault_any) begin
            state_q <= ST_ALARM;
          end
        end
        ST_ALARM: begin
          if (alarm_rel) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_ALARM;
        end
      endcase
    end
  end

  // all three drop on the same edge
  // halt is raised on that edge too
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alarm_ok_out_o          <= 1'b1;
      pulse_input_ready_out_o <= 1'b1;
      ready_o                 <= 1'b1;
      motor_halt_o            <= 1'b0;
    end else if (alarm_set) begin
      alarm_ok_out_o          <= 1'b0;
      pulse_input_ready_out_o <= 1'b0;
      ready_o                 <= 1'b0;
      motor_halt_o            <= 1'b1;
    end else if (alarm_rel) begin
      alarm_ok_out_o          <= 1'b1;
      pulse_input_ready_out_o <= 1'b1;
      ready_o                 <= 1'b1;
      motor_halt_o            <= 1'b0;
    end
  end

  // motion needs a fresh start after any alarm
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      armed_q         <= 1'b0;
      motion_active_o <= 1'b0;
    end else if (ce_i) begin
      if (alarm_set || state_q != ST_RUN) begin
        armed_q         <= 1'b0;
        motion_active_o <= 1'b0;
      end else begin
        armed_q         <= armed_q || op_start_i;
        motion_active_o <= op_busy_i && (armed_q || op_start_i);
      end
    end
  end

  // number, or -1 when stored data is not used
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op_info0_o <= OP_NUM_NONE;
    end else if (ce_i && op_start_i && state_q == ST_RUN && !fault_any) begin
      op_info0_o <= op_data_valid_i ? {1'b0, op_data_num_i} : OP_NUM_NONE;
    end
  end

  // reserved or out-of-range types read as idle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op_info1_o <= OP_TYPE_IDLE;
    end else if (ce_i) begin
      if (motion_active_o && op_type_i != OP_TYPE_RSVD
          && op_type_i <= OP_TYPE_MAX) begin
        op_info1_o <= op_type_i;
      end else begin
        op_info1_o <= OP_TYPE_IDLE;
      end
    end
  end

  // circular history, newest slot just below the pointer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wp_q  <= '0;
      cnt_q <= '0;
    end else if (alarm_set) begin
      wp_q  <= (wp_q == HIST_AW'(HIST_DEPTH - 1)) ? '0 : wp_q + 4'h1;
      if (cnt_q != HIST_AW'(HIST_DEPTH)) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  always_comb begin
    ri = 5'(wp_q) + 5'(HIST_DEPTH) - 5'h01 - 5'(sel_q);
    if (ri >= 5'(HIST_DEPTH)) begin
      ri = ri - 5'(HIST_DEPTH);
    end
  end

  assign hist_if.wr_en   = alarm_set;
  assign hist_if.wr_addr = wp_q;
  assign hist_if.wr_data = fault_code(fault_i);
  assign hist_if.rd_addr = ri[HIST_AW-1:0];

  mas_hist_mem #(.DEPTH(HIST_DEPTH), .DW(CODE_W)) u_hist (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .hif     (hist_if.mem)
  );

  // information path has no link to the halt logic
  mas_info #(.N(NINFO)) u_info (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .cond_i     (info_cond_i),
    .en_i       (info_en_q),
    .reflect_i  (info_refl_q),
    .auto_clr_i (ctrl_q[CTRL_AUTOCLR_BIT]),
    .clr_i      (info_clr),
    .bits_o     (info_bits_o),
    .info_o     (info_out_o),
    .raise_o    (info_raise)
  );

  // Bus slave: zero wait, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign acc    = ce_i && hsel_i && hready_i && htrans_i[1];
  assign rd_acc = acc && !hwrite_i;
  assign wr_now = ce_i && wr_pend_q;
  assign info_clr = (wr_now && wa_q == OFS_INFO_BITS)
                    ? hwdata_i[NINFO-1:0] : '0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wa_q      <= '0;
    end else if (ce_i) begin
      wr_pend_q <= acc && hwrite_i;
      wa_q      <= haddr_i[ADDR_W-1:0];
    end
  end

  // mechanism protection select, default follows sensor
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_q      <= CTRL_RST;
      mask_q      <= MASK_RST;
      info_en_q   <= {NINFO{INFO_EN_RST_BIT}};
      info_refl_q <= {NINFO{INFO_RF_RST_BIT}};
      sel_q       <= '0;
    end else if (wr_now) begin
      case (wa_q)
        OFS_CTRL:      ctrl_q      <= hwdata_i[1:0];
        OFS_MASK:      mask_q      <= hwdata_i[STAT_W-1:0];
        OFS_INFO_EN:   info_en_q   <= hwdata_i[NINFO-1:0];
        OFS_INFO_REFL: info_refl_q <= hwdata_i[NINFO-1:0];
        OFS_HIST_SEL:  sel_q       <= hwdata_i[HIST_AW-1:0];
        default: begin
        end
      endcase
    end
  end

  assign mech_prot_disable_o = ctrl_q[CTRL_MECH_BIT];

  // Sticky events; a read clears, a new event in that cycle survives
  assign stat_ev = {info_raise, alarm_rel, alarm_set};
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else if (ce_i) begin
      if (rd_acc && haddr_i[ADDR_W-1:0] == OFS_STATUS) begin
        stat_q <= stat_ev;
      end else begin
        stat_q <= stat_q | stat_ev;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(stat_q & mask_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr_i[ADDR_W-1:0])
      OFS_CTRL:      rdata_d = 32'(ctrl_q);
      OFS_STATUS:    rdata_d = 32'(stat_q);
      OFS_MASK:      rdata_d = 32'(mask_q);
      OFS_INFO_EN:   rdata_d = zext(info_en_q);
      OFS_INFO_REFL: rdata_d = zext(info_refl_q);
      OFS_INFO_BITS: rdata_d = zext(info_bits_o);
      OFS_OP_NUM:    rdata_d = {{23{op_info0_o[OPNUM_W]}}, op_info0_o};
      OFS_OP_TYPE:   rdata_d = 32'(op_info1_o);
      OFS_HIST_SEL:  rdata_d = 32'(sel_q);
      OFS_HIST_DATA: rdata_d = (sel_q < cnt_q) ? 32'(hist_if.rd_data)
                                               : 32'h0000_0000;
      OFS_HIST_CNT:  rdata_d = 32'(cnt_q);
      OFS_ALM_STATE: rdata_d = {22'h00_0000, 1'b0, fault_code(fault_i),
                                state_q == ST_ALARM};
      default:       rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_acc) begin
      hrdata_o <= rdata_d;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_fault_hit;
    alarm_set;
  endsequence
  sequence s_clear_ok;
    alarm_rel;
  endsequence

  a_alarm_drop: assert property (s_fault_hit |=>
    !alarm_ok_out_o && !pulse_input_ready_out_o && !motion_active_o)
    else $error("alarm outputs did not drop together");
  a_halt_now: assert property ($fell(alarm_ok_out_o) |->
    $rose(motor_halt_o))
    else $error("halt not raised with alarm");
  a_clear_release: assert property (s_clear_ok |=>
    alarm_ok_out_o && ready_o && pulse_input_ready_out_o && !motor_halt_o)
    else $error("release did not restore outputs");
  a_latch_hold: assert property (state_q == ST_ALARM && !alarm_rel |=>
    !alarm_ok_out_o && motor_halt_o)
    else $error("alarm left latch without clear");
  a_move_wait: assert property (s_clear_ok ##1 !op_start_i [*3] |=>
    !motion_active_o)
    else $error("motion rose without a new start");
  a_num_none: assert property (ce_i && op_start_i && !fault_any
    && state_q == ST_RUN && !op_data_valid_i |=> op_info0_o == OP_NUM_NONE)
    else $error("data number not -1 without stored data");
  a_num_hold: assert property (!(ce_i && op_start_i) |=>
    $stable(op_info0_o))
    else $error("data number changed while stopped");
  a_type_range: assert property (op_info1_o != OP_TYPE_RSVD
    && op_info1_o <= OP_TYPE_MAX)
    else $error("operation type out of range");
  a_mech_cfg: assert property (wr_now && wa_q == OFS_CTRL |=>
    mech_prot_disable_o == $past(hwdata_i[CTRL_MECH_BIT]))
    else $error("protection select not taken");
  a_hist_count: assert property (alarm_set
    && cnt_q < HIST_AW'(HIST_DEPTH) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("history count did not advance");
  a_info_nostop: assert property (ce_i && state_q == ST_RUN
    && !fault_any |=> !motor_halt_o)
    else $error("halt raised without a fault");
endmodule : mas_alarm_monitor

/* bench/mas_host_model.sv */
// Host controller model: alarm clear handshake and motion request.
// Assumes the monitor clock and registered monitor outputs.
`timescale 1ns/1ps
module mas_host_model (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic clr_req_i,
  input  wire logic early_clr_i,
  input  wire logic fault_on_i,
  input  wire logic alarm_ok_i,
  input  wire logic busy_req_i,
  output logic      alarm_clear_o,
  output logic      busy_o
);
  // clear once cause gone, held until ok
  // Early clear breaks the order, only when the bench asks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alarm_clear_o <= 1'h0;
    end else begin
      alarm_clear_o <= early_clr_i |
                       (clr_req_i & ~fault_on_i & ~alarm_ok_i);
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_o <= 1'h0;
    end else begin
      busy_o <= busy_req_i & ~clr_req_i;
    end
  end
endmodule : mas_host_model

/* bench/motor_alarm_status_monitor_tb_top.sv */
// Bench for the alarm and status monitor: bus tasks and scenarios.
// Assumes the host model owns clear and busy; slave never stalls.
`timescale 1ns/1ps
module motor_alarm_status_monitor_tb_top
  import mas_pkg::*;
;
  logic        clock_i   = 1'h0;
  logic        rst_i     = 1'h1;
  logic [7:0]  fault     = 8'h00;
  logic        clr_req   = 1'h0;
  logic        early_clr = 1'h0;
  logic        busy_req  = 1'h0;
  logic        op_start  = 1'h0;
  logic        op_valid  = 1'h0;
  logic [7:0]  op_num    = 8'h00;
  logic [3:0]  op_type   = 4'h0;
  logic [7:0]  cond      = 8'h00;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'h0;
  logic [31:0] hwdata    = 32'h0;
  logic        clr;
  logic        busy;
  logic        hready;
  logic        hresp;
  logic        ok;
  logic        prdy;
  logic        mot;
  logic        rdy;
  logic        halt;
  logic        mech;
  logic        info_out;
  logic        irq;
  logic [8:0]  info0;
  logic [3:0]  info1;
  logic [7:0]  ibits;
  logic [31:0] hrdata;
  int          errors    = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  always #5 clock_i = ~clock_i;

  mas_alarm_monitor mas_alarm_monitor_inst (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'h1), .fault_i(fault),
    .alarm_clear_in_i(clr), .op_start_i(op_start), .op_busy_i(busy),
    .op_data_valid_i(op_valid), .op_data_num_i(op_num),
    .op_type_i(op_type), .info_cond_i(cond), .hsel_i(1'h1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .alarm_ok_out_o(ok), .pulse_input_ready_out_o(prdy),
    .motion_active_o(mot), .ready_o(rdy), .motor_halt_o(halt),
    .mech_prot_disable_o(mech), .op_info0_o(info0),
    .op_info1_o(info1), .info_bits_o(ibits), .info_out_o(info_out),
    .irq_o(irq));

  mas_host_model mas_host_model_inst (
    .clock_i(clock_i), .rst_i(rst_i), .clr_req_i(clr_req),
    .early_clr_i(early_clr), .fault_on_i(|fault), .alarm_ok_i(ok),
    .busy_req_i(busy_req), .alarm_clear_o(clr), .busy_o(busy));

  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      errors++;
    end
  endtask : chk

  // Single word transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clock_i); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_i); while (hready !== 1'h1);
    q = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd

  task automatic start(input logic v, input logic [7:0] n);
    @(posedge clock_i);
    op_start <= 1'h1;
    op_valid <= v;
    op_num   <= n;
    @(posedge clock_i);
    op_start <= 1'h0;
  endtask : start

  task automatic raise(input logic [7:0] f);
    @(posedge clock_i);
    fault <= f;
    // Fault is taken at the next edge, outputs settle after it
    repeat (2) @(negedge clock_i);
    chk("alarm_ok", 32'h0, ok);
    chk("pulse_rdy", 32'h0, prdy);
    chk("motion", 32'h0, mot);
    chk("ready", 32'h0, rdy);
    chk("halt", 32'h1, halt);
  endtask : raise

  // Clear with fault still present must be ignored
  task automatic release_alarm();
    int n;
    @(posedge clock_i);
    early_clr <= 1'h1;
    @(posedge clock_i);
    early_clr <= 1'h0;
    repeat (3) @(negedge clock_i);
    chk("alarm_ok held", 32'h0, ok);
    @(posedge clock_i);
    fault   <= 8'h00;
    clr_req <= 1'h1;
    for (n = 0; n < 10 && ok !== 1'h1; n++) @(negedge clock_i);
    chk("alarm_ok", 32'h1, ok);
    chk("ready", 32'h1, rdy);
    chk("pulse_rdy", 32'h1, prdy);
    chk("halt", 32'h0, halt);
    chk("motion", 32'h0, mot);
    @(posedge clock_i);
    clr_req <= 1'h0;
    repeat (3) @(negedge clock_i);
    chk("motion idle", 32'h0, mot);
  endtask : release_alarm

  task automatic scen_reset();
    @(negedge clock_i);
    chk("alarm_ok", 32'h1, ok);
    chk("op_info0", 32'h1FF, info0);
    chk("op_info1", 32'h0, info1);
    rd(OFS_CTRL, {30'h0, CTRL_RST}, "ctrl");
    rd(OFS_MASK, 32'h0, "mask");
    rd(OFS_INFO_EN, 32'h0000_00FF, "info_en");
    rd(OFS_INFO_REFL, 32'h0000_00FF, "info_refl");
    rd(OFS_OP_NUM, 32'hFFFF_FFFF, "op_num");
    rd(OFS_HIST_CNT, 32'h0, "hist_cnt");
    wr(OFS_STATUS, 32'h0000_0007);
    rd(OFS_STATUS, 32'h0, "status ro");
    rd(8'h30, 32'h0, "unmapped");
  endtask : scen_reset

  task automatic scen_status();
    int t;
    @(posedge clock_i);
    busy_req <= 1'h1;
    start(1'h1, 8'hFF);
    @(negedge clock_i);
    chk("op_info0", 32'h0FF, info0);
    chk("motion", 32'h1, mot);
    for (t = 0; t < 14; t++) begin
      @(posedge clock_i);
      op_type <= t[3:0];
      repeat (2) @(negedge clock_i);
      chk("op_info1", (t == 12) ? 32'h0 : 32'(t), info1);
    end
    @(posedge clock_i);
    busy_req <= 1'h0;
    repeat (3) @(negedge clock_i);
    chk("op_info0 held", 32'h0FF, info0);
    rd(OFS_OP_NUM, 32'h0000_00FF, "op_num");
    start(1'h0, 8'h05);
    @(negedge clock_i);
    chk("op_info0 none", 32'h1FF, info0);
  endtask : scen_status

  task automatic scen_alarm();
    int i;
    @(posedge clock_i);
    busy_req <= 1'h1;
    start(1'h1, 8'h10);
    @(negedge clock_i);
    chk("motion", 32'h1, mot);
    raise(8'h04);
    release_alarm();
    rd(OFS_STATUS, 32'h0000_0003, "status");
    wr(OFS_MASK, 32'h0000_0001);
    raise(8'h01);
    repeat (2) @(negedge clock_i);
    chk("irq", 32'h1, irq);
    rd(OFS_ALM_STATE, 32'h0000_0003, "alm_state");
    release_alarm();
    rd(OFS_STATUS, 32'h0000_0003, "status");
    repeat (2) @(negedge clock_i);
    chk("irq clr", 32'h0, irq);
    wr(OFS_MASK, 32'h0);
    for (i = 0; i < 11; i++) begin
      raise(8'(1 << (i % 8)));
      release_alarm();
    end
    rd(OFS_HIST_CNT, 32'h0000_000A, "hist_cnt");
    rd(OFS_HIST_DATA, 32'h0000_0003, "hist 0");
    wr(OFS_HIST_SEL, 32'h0000_0009);
    rd(OFS_HIST_DATA, 32'h0000_0002, "hist 9");
    wr(OFS_HIST_SEL, 32'h0000_000A);
    rd(OFS_HIST_DATA, 32'h0, "hist 10");
  endtask : scen_alarm

  task automatic scen_info();
    logic [31:0] q;
    bus(1'h0, OFS_STATUS, 32'h0, q);
    wr(OFS_MASK, 32'h0000_0004);
    @(posedge clock_i);
    cond <= 8'h01;
    // Flag, then status bit, then registered irq: three edges
    repeat (4) @(negedge clock_i);
    chk("info_bits", 32'h1, ibits);
    chk("info_out", 32'h1, info_out);
    chk("halt", 32'h0, halt);
    chk("alarm_ok", 32'h1, ok);
    chk("irq", 32'h1, irq);
    rd(OFS_STATUS, 32'h0000_0004, "status info");
    repeat (2) @(negedge clock_i);
    chk("irq clr", 32'h0, irq);
    wr(OFS_INFO_REFL, 32'h0000_00FD);
    @(posedge clock_i);
    cond <= 8'h02;
    repeat (3) @(negedge clock_i);
    chk("info_bits", 32'h2, ibits);
    chk("info_out own", 32'h0, info_out);
    wr(OFS_CTRL, 32'h0000_0001);
    @(negedge clock_i);
    chk("mech", 32'h1, mech);
    @(posedge clock_i);
    cond <= 8'h00;
    repeat (3) @(negedge clock_i);
    chk("info sticky", 32'h2, ibits);
    wr(OFS_INFO_BITS, 32'h0000_0002);
    rd(OFS_INFO_BITS, 32'h0, "info cleared");
    rd(OFS_CTRL, 32'h0000_0001, "ctrl");
  endtask : scen_info

  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'h0;
    scen_reset();
    scen_status();
    scen_alarm();
    scen_info();
    final_report();
  end

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clock_i) begin
    cyc++;
    if (cyc >= 8000) begin
      errors++;
      final_report();
    end
  end
endmodule : motor_alarm_status_monitor_tb_top
